// ### src/mfgp_consts.svh
`ifndef MFGP_CONSTS_SVH
`define MFGP_CONSTS_SVH
// Register byte offsets.
`define MFGP_CFG_BASE   12'h000
`define MFGP_CFG_LAST   12'h03C
`define MFGP_GPO_OFF    12'h040
`define MFGP_GPI_OFF    12'h044
`define MFGP_STKY_OFF   12'h048
`define MFGP_AEN_OFF    12'h04C
`define MFGP_STAT_OFF   12'h050
// Pin configuration word fields.
`define MFGP_F_MODE_LO  0
`define MFGP_F_MODE_HI  3
`define MFGP_F_INV      4
`define MFGP_F_EN       5
`define MFGP_F_OD       6
`define MFGP_F_REF_LO   8
`define MFGP_F_REF_HI   11
`define MFGP_F_CH_LO    12
`define MFGP_F_CH_HI    13
`define MFGP_F_MSK_LO   16
`define MFGP_F_MSK_HI   31
// Alert enable word fields.
`define MFGP_F_GLOBAL   8
// Reset values.
`define MFGP_CFG_RST    32'h0000_0000
`define MFGP_GPO_RST    16'h0000
`define MFGP_AEN_RST    9'h000
`endif

// ### src/mfgp_pkg.sv
package mfgp_pkg;
  // Pin operating modes held in the mode field of each pin word.
  typedef enum logic [3:0] {
    MFGP_GPI      = 4'h0,
    MFGP_GPO      = 4'h1,
    MFGP_SIGLOSS  = 4'h2,
    MFGP_LOL_LIVE = 4'h3,
    MFGP_LOL_STKY = 4'h4,
    MFGP_HO_LIVE  = 4'h5,
    MFGP_HO_STKY  = 4'h6,
    MFGP_ALERT    = 4'h7,
    MFGP_OUTDIS   = 4'h8,
    MFGP_SECLK    = 4'h9,
    MFGP_MANSEL   = 4'hA,
    MFGP_INC      = 4'hB,
    MFGP_DEC      = 4'hC,
    MFGP_DISQ     = 4'hD
  } mfgp_mode_e;
  typedef logic [31:0] mfgp_cfg_t;
endpackage

// ### src/mfgp_top.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mfgp_consts.svh"
module mfgp_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reset_done,
  input  wire logic [15:0] gpio_i,
  output logic      [15:0] gpio_o,
  output logic      [15:0] gpio_oe,
  input  wire logic [15:0] ref_alarm,
  input  wire logic [3:0]  pll_locked,
  input  wire logic [3:0]  pll_holdover,
  output logic      [15:0] clk_out_disable,
  output logic      [15:0] se_clk_enable,
  output logic      [3:0]  man_sel_en,
  output logic      [3:0]  man_sel_high,
  output logic      [3:0]  oscillator_inc,
  output logic      [3:0]  oscillator_dec,
  output logic      [63:0] ref_disqualify
);

  // Field helpers, shared by the pin logic and the bus decode.
  function automatic mfgp_pkg::mfgp_mode_e mode_of(input mfgp_pkg::mfgp_cfg_t c);
    mode_of = mfgp_pkg::mfgp_mode_e'(c[`MFGP_F_MODE_HI:`MFGP_F_MODE_LO]);
  endfunction

  function automatic logic [1:0] ch_of(input mfgp_pkg::mfgp_cfg_t c);
    ch_of = c[`MFGP_F_CH_HI:`MFGP_F_CH_LO];
  endfunction

  function automatic logic [3:0] ref_of(input mfgp_pkg::mfgp_cfg_t c);
    ref_of = c[`MFGP_F_REF_HI:`MFGP_F_REF_LO];
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `MFGP_STAT_OFF);
  endfunction

  mfgp_pkg::mfgp_cfg_t cfg_q [16];
  logic [15:0] gpo_q;
  logic [15:0] gpi_q;
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic [15:0] prev_q;
  logic [7:0]  sticky_q;
  logic [7:0]  sticky_d;
  logic [3:0]  lock_prev_q;
  logic [3:0]  ho_prev_q;
  logic [8:0]  aen_q;
  logic        done_q;
  logic        alert_w;
  logic        wr;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic [15:0] o_d;
  logic [15:0] oe_d;
  logic [15:0] dis_d;
  logic [15:0] se_d;
  logic [3:0]  msen_d;
  logic [3:0]  mshi_d;
  logic [3:0]  inc_d;
  logic [3:0]  dec_d;
  logic [63:0] disq_d;
  logic [15:0] o_q;
  logic [15:0] oe_q;
  logic [15:0] dis_q;
  logic [15:0] se_q;
  logic [3:0]  msen_q;
  logic [3:0]  mshi_q;
  logic [3:0]  inc_q;
  logic [3:0]  dec_q;
  logic [63:0] disq_q;

  // The bus never waits; an unmapped word answers with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata  = prdata_q;
  assign wr      = psel && penable && pwrite && addr_ok(paddr);

  // two stage sync
  // Pins pass two flops; the third keeps the last synced level for edges.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      prev_q  <= 16'h0000;
    end else begin
      sync1_q <= gpio_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // input capture
  // The readable input word follows every pin, whatever its mode.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gpi_q <= 16'h0000;
    end else begin
      gpi_q <= sync2_q;
    end
  end

  // reset sequence gate
  // Modes act only once the device reset sequence reports completion.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= reset_done;
    end
  end

  // per pin words
  // Software writes the sixteen pin words and the output value word.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        cfg_q[i] <= `MFGP_CFG_RST;
      end
      gpo_q <= `MFGP_GPO_RST;
      aen_q <= `MFGP_AEN_RST;
    end else if (wr) begin
      if (paddr <= `MFGP_CFG_LAST) begin
        cfg_q[paddr[5:2]] <= pwdata;
      end else if (paddr == `MFGP_GPO_OFF) begin
        gpo_q <= pwdata[15:0];
      end else if (paddr == `MFGP_AEN_OFF) begin
        aen_q <= pwdata[8:0];
      end
    end
  end

  // sticky set and clear
  // A change of lock or holdover state sets a bit; a one written clears it.
  always_comb begin
    sticky_d = sticky_q;
    if (wr && paddr == `MFGP_STKY_OFF) begin
      sticky_d = sticky_d & ~pwdata[7:0];
    end
    // A change in the clearing cycle still sets the bit.
    sticky_d = sticky_d | {ho_prev_q ^ pll_holdover, lock_prev_q ^ pll_locked};
  end

  // Sticky bits and the history of the watched states.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sticky_q    <= 8'h00;
      lock_prev_q <= 4'h0;
      ho_prev_q   <= 4'h0;
    end else begin
      sticky_q    <= sticky_d;
      lock_prev_q <= pll_locked;
      ho_prev_q   <= pll_holdover;
    end
  end

  // alert aggregation
  // Only enabled sticky bits reach the alert, under the global enable.
  assign alert_w = aen_q[`MFGP_F_GLOBAL] && |(sticky_q & aen_q[7:0]);

  // Read data is latched in the setup cycle and shown in the access cycle.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr <= `MFGP_CFG_LAST) begin
      rdata_d = cfg_q[paddr[5:2]];
    end else if (paddr == `MFGP_GPO_OFF) begin
      rdata_d = {16'h0000, gpo_q};
    end else if (paddr == `MFGP_GPI_OFF) begin
      rdata_d = {16'h0000, gpi_q};
    end else if (paddr == `MFGP_STKY_OFF) begin
      rdata_d = {24'h000000, sticky_q};
    end else if (paddr == `MFGP_AEN_OFF) begin
      rdata_d = {23'h000000, aen_q};
    end else if (paddr == `MFGP_STAT_OFF) begin
      rdata_d = {22'h000000, pll_holdover, pll_locked, done_q, alert_w};
    end
  end

  // Read data register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rdata_d;
    end
  end

  // Per pin behaviour: output value, drive enable and control strobes.
  always_comb begin
    logic                 v;
    logic                 isout;
    logic                 s;
    logic [1:0]           ch;
    logic [3:0]           rf;
    mfgp_pkg::mfgp_cfg_t  c;
    v      = 1'b0;
    isout  = 1'b0;
    s      = 1'b0;
    ch     = 2'h0;
    rf     = 4'h0;
    c      = '0;
    o_d    = 16'h0000;
    oe_d   = 16'h0000;
    dis_d  = 16'h0000;
    se_d   = 16'h0000;
    msen_d = 4'h0;
    mshi_d = 4'h0;
    inc_d  = 4'h0;
    dec_d  = 4'h0;
    disq_d = 64'h0;
    for (int i = 0; i < 16; i++) begin
      c     = cfg_q[i];
      ch    = ch_of(c);
      rf    = ref_of(c);
      s     = sync2_q[i];
      isout = 1'b1;
      // same config same value, except in output mode
      // Pins with the same pin word take the same value, except in output mode, where each pin takes its own bit of gpo_q.
      case (mode_of(c))
        mfgp_pkg::MFGP_GPO: v = gpo_q[i];
        mfgp_pkg::MFGP_SIGLOSS: v = ref_alarm[rf] ^ c[`MFGP_F_INV];
        mfgp_pkg::MFGP_LOL_LIVE: v = !pll_locked[ch] ^ c[`MFGP_F_INV];
        mfgp_pkg::MFGP_LOL_STKY: v = sticky_q[ch] ^ c[`MFGP_F_INV];
        mfgp_pkg::MFGP_HO_LIVE: v = pll_holdover[ch] ^ c[`MFGP_F_INV];
        mfgp_pkg::MFGP_HO_STKY: v = sticky_q[{1'b1, ch}] ^ c[`MFGP_F_INV];
        mfgp_pkg::MFGP_ALERT: v = alert_w ^ c[`MFGP_F_INV];
        default: begin
          v     = 1'b0;
          isout = 1'b0;
        end
      endcase
      o_d[i]  = c[`MFGP_F_OD] ? 1'b0 : v;
      oe_d[i] = done_q && c[`MFGP_F_EN] && isout && (!c[`MFGP_F_OD] || !v);
      if (done_q) begin
        case (mode_of(c))
          mfgp_pkg::MFGP_OUTDIS: dis_d = dis_d | (s ? c[`MFGP_F_MSK_HI:`MFGP_F_MSK_LO] : 16'h0000);
          mfgp_pkg::MFGP_SECLK: se_d[i] = 1'b1;
          mfgp_pkg::MFGP_MANSEL: begin
            msen_d[ch] = 1'b1;
            mshi_d[ch] = mshi_d[ch] | s;
          end
          mfgp_pkg::MFGP_INC: inc_d[ch] = inc_d[ch] | (s && !prev_q[i]);
          mfgp_pkg::MFGP_DEC: dec_d[ch] = dec_d[ch] | (s && !prev_q[i]);
          mfgp_pkg::MFGP_DISQ: disq_d[{ch, rf}] = disq_d[{ch, rf}] | s;
          default: se_d[i] = se_d[i];
        endcase
      end
    end
  end

  // Pin and control outputs all come from flops.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      o_q    <= 16'h0000;
      oe_q   <= 16'h0000;
      dis_q  <= 16'h0000;
      se_q   <= 16'h0000;
      msen_q <= 4'h0;
      mshi_q <= 4'h0;
      inc_q  <= 4'h0;
      dec_q  <= 4'h0;
      disq_q <= 64'h0;
    end else begin
      o_q    <= o_d;
      oe_q   <= oe_d;
      dis_q  <= dis_d;
      se_q   <= se_d;
      msen_q <= msen_d;
      mshi_q <= mshi_d;
      inc_q  <= inc_d;
      dec_q  <= dec_d;
      disq_q <= disq_d;
    end
  end

  // Output ports.
  assign gpio_o          = o_q;
  assign gpio_oe         = oe_q;
  assign clk_out_disable = dis_q;
  assign se_clk_enable   = se_q;
  assign man_sel_en      = msen_q;
  assign man_sel_high    = mshi_q;
  assign oscillator_inc  = inc_q;
  assign oscillator_dec  = dec_q;
  assign ref_disqualify  = disq_q;

  // Each check watches a pin or channel that the bench drives; every pin shares the same logic.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_GPI_CAPTURE: assert property ($past(nrst, 3) |-> gpi_q == $past(gpio_i, 3))
    else $error("Input word does not follow the pin after three cycles.");

  AST_PRE_DONE: assert property (!done_q |=> (gpio_oe == 16'h0000 && oscillator_inc == 4'h0))
    else $error("Pin acted before the reset sequence completed.");

  AST_GPO_DRIVE: assert property (done_q && mode_of(cfg_q[0]) == mfgp_pkg::MFGP_GPO && cfg_q[0][5]
      && !cfg_q[0][6] |=> gpio_oe[0] && gpio_o[0] == $past(gpo_q[0]))
    else $error("Output mode pin not driven to its register bit.");

  AST_OPEN_DRAIN: assert property ($past(cfg_q[1][6]) && gpio_oe[1] |-> !gpio_o[1])
    else $error("Open drain pin driven high.");

  AST_STICKY_SET: assert property ($changed(pll_locked[1]) |=> sticky_q[1])
    else $error("Lock change did not set the sticky bit.");

  AST_STICKY_HOLD: assert property (sticky_q[5] && !(wr && paddr == `MFGP_STKY_OFF && pwdata[5])
      |=> sticky_q[5])
    else $error("Sticky holdover bit dropped without a clear.");

  AST_ALERT_OFF: assert property (done_q && mode_of(cfg_q[5]) == mfgp_pkg::MFGP_ALERT && !cfg_q[5][6]
      && (sticky_q & aen_q[7:0]) == 8'h00 |=> gpio_o[5] == $past(cfg_q[5][4]))
    else $error("Alert pin raised with no enabled sticky bit.");

  AST_INC_EDGE: assert property (done_q && mode_of(cfg_q[8]) == mfgp_pkg::MFGP_INC
      && ch_of(cfg_q[8]) == 2'h2 && $rose(sync2_q[8]) |=> oscillator_inc[2])
    else $error("Rising edge did not give an increment.");

  AST_OUTDIS: assert property (done_q && mode_of(cfg_q[10]) == mfgp_pkg::MFGP_OUTDIS
      && cfg_q[10][16] && sync2_q[10] |=> clk_out_disable[0])
    else $error("High disable input left the selected clock enabled.");

  COV_STICKY_CLEAR: cover property (sticky_q[1] ##1 !sticky_q[1]);
  COV_ALERT: cover property (alert_w);
  COV_INC: cover property (oscillator_inc[2]);
  COV_DISQ: cover property (ref_disqualify != 64'h0);

endmodule
`default_nettype wire

// ### tb/mfgp_board.sv
`timescale 1ns/1ns
`default_nettype none
// Board side of the sixteen pins: a board driver per pin plus the weak pull-up.
module mfgp_board (
  input  wire logic [15:0] gpio_o,
  input  wire logic [15:0] gpio_oe,
  input  wire logic [15:0] ext_drv,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] gpio_i
);
  // pin level resolution
  // A pin driven by the device shows its value, else the board value, else the pull-up.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      gpio_i[i] = gpio_oe[i] ? gpio_o[i] : (ext_drv[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ### tb/multifunction_gpio_pins_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Register and pin level test of the general purpose pin bank.
module multifunction_gpio_pins_tb_top;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, reset_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] gpio_i, gpio_o, gpio_oe, ref_alarm, ext_val, clk_out_disable, se_clk_enable;
  logic [3:0]  pll_locked, pll_holdover, man_sel_en, man_sel_high, oscillator_inc, oscillator_dec;
  logic [63:0] ref_disqualify;
  logic        e;
  int          fails, n_checks, n_inc, n_dec;

  mfgp_top i_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_done(reset_done), .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .ref_alarm(ref_alarm), .pll_locked(pll_locked), .pll_holdover(pll_holdover),
    .clk_out_disable(clk_out_disable), .se_clk_enable(se_clk_enable), .man_sel_en(man_sel_en),
    .man_sel_high(man_sel_high), .oscillator_inc(oscillator_inc), .oscillator_dec(oscillator_dec),
    .ref_disqualify(ref_disqualify));
  mfgp_board i_board (.gpio_o(gpio_o), .gpio_oe(gpio_oe), .ext_drv(16'hFFFF), .ext_val(ext_val),
    .gpio_i(gpio_i));

  // Clock generation at 25 MHz.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Counts of oscillator step pulses on channel 2.
  always @(posedge mclk) begin
    if (oscillator_inc[2] === 1'b1) n_inc++;
    if (oscillator_dec[2] === 1'b1) n_dec++;
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high, then one idle cycle follows.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge mclk);
    end
    if (k == 20) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // Register read compared against an expected word.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("read", x, q);
  endtask

  // Lets the given number of clock edges pass.
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog against a hung handshake or sequence.
  initial begin
    #200000;
    fails++;
    results;
  end

  // Main sequence.
  initial begin
    nrst         = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    reset_done   = 1'b0;
    ref_alarm    = 16'h0000;
    pll_locked   = 4'h0;
    pll_holdover = 4'h0;
    ext_val      = 16'hA5C3;
    fails        = 0;
    n_checks     = 0;
    n_inc        = 0;
    n_dec        = 0;
    w(2);
    nrst <= 1'b1;
    w(1);
    rd_chk(12'h000, 32'h0000_0000);
    rd_chk(12'h03C, 32'h0000_0000);
    apb(1'b0, 12'h060, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, 12'h000, 32'h0000_0021);
    apb(1'b1, 12'h040, 32'h0000_0001);
    w(3);
    chk("oe", 32'h0, {16'h0, gpio_oe});
    $display("test reset done");
    reset_done <= 1'b1;
    w(5);
    rd_chk(12'h044, 32'h0000_A5C3);
    chk("o0", 32'h1, {31'h0, gpio_o[0]});
    chk("oe0", 32'h1, {31'h0, gpio_oe[0]});
    apb(1'b1, 12'h004, 32'h0000_0061);
    w(3);
    chk("od low", 32'h2, {30'h0, gpio_oe[1], gpio_o[1]});
    apb(1'b1, 12'h040, 32'h0000_0003);
    w(3);
    chk("od rel", 32'h0, {31'h0, gpio_oe[1]});
    $display("test gpio done");
    apb(1'b1, 12'h008, 32'h0000_0322);
    apb(1'b1, 12'h00C, 32'h0000_0322);
    ref_alarm <= 16'h0008;
    w(3);
    chk("los", 32'h3, {30'h0, gpio_o[3:2]});
    apb(1'b1, 12'h00C, 32'h0000_0332);
    ref_alarm <= 16'h0000;
    w(3);
    chk("los inv", 32'h2, {30'h0, gpio_o[3:2]});
    $display("test signal loss done");
    apb(1'b1, 12'h010, 32'h0000_1024);
    apb(1'b1, 12'h014, 32'h0000_0027);
    apb(1'b1, 12'h04C, 32'h0000_0102);
    apb(1'b1, 12'h018, 32'h0000_1023);
    apb(1'b1, 12'h01C, 32'h0000_1025);
    w(3);
    chk("live", 32'h1, {30'h0, gpio_o[7:6]});
    pll_locked <= 4'h2;
    pll_holdover <= 4'h2;
    w(4);
    chk("stky", 32'h3, {30'h0, gpio_o[5:4]});
    chk("live2", 32'h2, {30'h0, gpio_o[7:6]});
    rd_chk(12'h048, 32'h0000_0022);
    apb(1'b1, 12'h048, 32'h0000_0002);
    w(3);
    chk("clr", 32'h0, {30'h0, gpio_o[5:4]});
    rd_chk(12'h048, 32'h0000_0020);
    apb(1'b1, 12'h034, 32'h0000_1026);
    // host keeps rule: pin 14 feeds an input stage with no single-ended references on its clock pins.
    apb(1'b1, 12'h038, 32'h0000_0009);
    w(3);
    chk("ho stky", 32'h1, {31'h0, gpio_o[13]});
    chk("se clk", 32'h0000_4000, {16'h0, se_clk_enable});
    $display("test alarm done");
    apb(1'b1, 12'h020, 32'h0000_200B);
    apb(1'b1, 12'h024, 32'h0000_200C);
    apb(1'b1, 12'h028, 32'h0005_0008);
    apb(1'b1, 12'h02C, 32'h0000_300A);
    apb(1'b1, 12'h030, 32'h0000_150D);
    ext_val <= 16'h0000;
    w(5);
    n_inc = 0;
    n_dec = 0;
    ext_val <= 16'h1F00;
    w(6);
    chk("inc", 32'h1, n_inc);
    chk("dec", 32'h1, n_dec);
    chk("odis", 32'h5, {16'h0, clk_out_disable});
    chk("msel", 32'h3, {30'h0, man_sel_en[3], man_sel_high[3]});
    chk("disq", 32'h1, {31'h0, ref_disqualify[21]});
    ext_val <= 16'h0000;
    w(6);
    chk("odis0", 32'h0, {16'h0, clk_out_disable});
    $display("test control done");
    results;
  end
endmodule
`default_nettype wire
